// >>> pfs_pkg.sv
// pfs_pkg: shared constants, pin indices and function codes of the pin mux
package pfs_pkg;

  // ****************************************
  // pins that own a selector register
  // ****************************************
  localparam int NPIN = 15;
  localparam int PIN_P20 = 0;
  localparam int PIN_P21 = 1;
  localparam int PIN_P22 = 2;
  localparam int PIN_P23 = 3;
  localparam int PIN_P24 = 4;
  localparam int PIN_P27 = 5;
  localparam int PIN_P30 = 6;
  localparam int PIN_P31 = 7;
  localparam int PIN_P32 = 8;
  localparam int PIN_P33 = 9;
  localparam int PIN_P36 = 10;
  localparam int PIN_P37 = 11;
  localparam int PIN_P70 = 12;
  localparam int PIN_P71 = 13;
  localparam int PIN_P72 = 14;

  // ****************************************
  // register map and field layout
  // ****************************************
  localparam int ADDR_W = 12;
  localparam int REG_STRIDE = 4;
  localparam logic [ADDR_W-1:0] REG_BASE = 12'h000;
  localparam int SEL_LSB = 0;
  localparam int SEL_W = 6;
  localparam int IRQ_FLAG_BIT = 6;
  localparam int ANA_FLAG_BIT = 7;
  localparam int CFG_W = 8;
  localparam logic [CFG_W-1:0] CFG_RESET = 8'h00;
  localparam int NIRQ = 16;
  localparam int NO_IRQ = -1;
  localparam int NANA = 2;

  // ****************************************
  // routing codes
  // ****************************************
  localparam logic [5:0] CODE_HIZ = 6'h00;
  localparam logic [5:0] CODE_MTU_A = 6'h01;
  localparam logic [5:0] CODE_MTU_B = 6'h02;
  localparam logic [5:0] CODE_MTU_A_INV = 6'h03;
  localparam logic [5:0] CODE_MTU_B_INV = 6'h04;
  localparam logic [5:0] CODE_TMR_A = 6'h05;
  localparam logic [5:0] CODE_TMR_B = 6'h06;
  localparam logic [5:0] CODE_POE = 6'h07;
  localparam logic [5:0] CODE_ADC_TRG = 6'h09;
  localparam logic [5:0] CODE_SPIA = 6'h0D;
  localparam logic [5:0] CODE_SPI0 = 6'h0E;
  localparam logic [5:0] CODE_GPT_A = 6'h14;
  localparam logic [5:0] CODE_GPT_B = 6'h15;
  localparam logic [5:0] CODE_GPT_B_INV = 6'h17;
  localparam logic [5:0] CODE_WAVE = 6'h18;
  localparam logic [5:0] CODE_SCI_A = 6'h2C;
  localparam logic [5:0] CODE_SCI_B = 6'h2D;
  localparam logic [5:0] CODE_SCI_C = 6'h2E;

  // ****************************************
  // on-chip peripheral signals
  // ****************************************
  typedef enum logic [5:0] {
    FN_NONE, FN_MTU_CH9_C_IO, FN_MTU_CH9_C_IO_INVERTED, FN_MTU_EXT_CLOCK_B,
    FN_MTU_EXT_CLOCK_B_INVERTED, FN_TIMER4_RESET_INPUT, FN_TIMER2_OUTPUT,
    FN_TIMER6_OUTPUT, FN_CONVERTER0_TRIGGER_INPUT, FN_SPI_A_CLOCK,
    FN_SPI_UNIT0_CLOCK, FN_SPI_UNIT0_MASTER_OUT, FN_SPI_UNIT0_MASTER_IN,
    FN_SPI_UNIT0_SLAVE_SELECT0, FN_SPI_UNIT0_SLAVE_SELECT1,
    FN_SPI_A_SLAVE_SELECT1, FN_HALL_W_INPUT, FN_HALL_U_INPUT,
    FN_HALL_V_INPUT, FN_SERIAL008_HANDSHAKE_SELECT, FN_SERIAL008_RECEIVE,
    FN_SERIAL008_TRANSMIT, FN_SERIAL008_CLOCK, FN_SERIAL008_DRIVER_ENABLE,
    FN_SERIAL009_HANDSHAKE_SELECT, FN_SERIAL009_DRIVER_ENABLE,
    FN_OUTPUT_ENABLE_REQUEST9, FN_GPT_CH7_A_IO, FN_GPT_CH7_A_IO_INVERTED,
    FN_GPT_CH7_B_IO, FN_GPT_CH7_B_IO_INVERTED, FN_GPT_CH0_A_IO,
    FN_GPT_CH5_A_IO_INVERTED, FN_COMPLEMENTARY_PERIOD_OUTPUT00,
    FN_PWM_V_UPPER_OUTPUT, FN_COUNT
  } pfs_fn_t;
  localparam int NFN = int'(FN_COUNT);

  // interrupt line served by each pin, NO_IRQ where none
  function automatic int irq_of(input int pin);
    case (pin)
      PIN_P20: irq_of = 7;
      PIN_P21: irq_of = 6;
      PIN_P22: irq_of = 10;
      PIN_P23: irq_of = 11;
      PIN_P24: irq_of = 4;
      PIN_P27: irq_of = 15;
      PIN_P30: irq_of = 7;
      PIN_P31: irq_of = 6;
      PIN_P32: irq_of = 12;
      PIN_P33: irq_of = 13;
      default: irq_of = NO_IRQ;
    endcase
  endfunction : irq_of

  // only the two converter-capable pins keep an analog flag
  function automatic bit has_analog(input int pin);
    has_analog = (pin == PIN_P20) || (pin == PIN_P21);
  endfunction : has_analog

endpackage : pfs_pkg

// >>> pfs_cfg_if.sv
// pfs_cfg_if: selector register contents passed from bank to mux
`timescale 1ns/100ps
`default_nettype none
interface pfs_cfg_if;
  import pfs_pkg::*;
  logic [NPIN-1:0][CFG_W-1:0] cfg;
  modport bank(output cfg);
  modport user(input cfg);
endinterface : pfs_cfg_if
`default_nettype wire

// >>> pfs_apb_bank.sv
// pfs_apb_bank: apb slave holding the pin selector registers
`timescale 1ns/100ps
`default_nettype none
module pfs_apb_bank (
  input wire logic pclk,
  input wire logic presetn,
  input wire logic psel,
  input wire logic penable,
  input wire logic pwrite,
  input wire logic [pfs_pkg::ADDR_W-1:0] paddr,
  input wire logic [31:0] pwdata,
  output logic [31:0] prdata,
  output logic pready,
  output logic pslverr,
  pfs_cfg_if.bank cfg_if
);
  import pfs_pkg::*;

  logic [NPIN-1:0][CFG_W-1:0] cfg_ff;
  logic pready_ff;
  logic pslverr_ff;
  logic [31:0] prdata_ff;
  logic hit;
  int unsigned idx;

  // ****************************************
  // decode
  // ****************************************
  always_comb begin
    idx = 32'((paddr - REG_BASE) / REG_STRIDE);
    hit = (paddr >= REG_BASE) && (paddr[1:0] == 2'h0) && (idx < NPIN);
  end

  // writable bits: analog flag only where a converter input exists
  function automatic logic [CFG_W-1:0] wmask(input int pin);
    wmask = '1;
    if (!has_analog(pin)) begin
      wmask[ANA_FLAG_BIT] = 1'b0;
    end
  endfunction : wmask

  // one wait-free access cycle; answer comes from flops
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      pready_ff <= 1'b0;
    end else begin
      pready_ff <= psel && !penable;
    end
  end

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      prdata_ff <= 32'h00000000;
      pslverr_ff <= 1'b0;
    end else if (psel && !penable) begin
      prdata_ff <= hit ? {24'h000000, cfg_ff[idx]} : 32'h00000000;
      pslverr_ff <= !hit;
    end
  end

  // writes land only at the completing edge
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      cfg_ff <= {NPIN{CFG_RESET}};
    end else if (psel && penable && pready_ff && pwrite && hit) begin
      cfg_ff[idx] <= pwdata[CFG_W-1:0] & wmask(int'(idx));
    end
  end

  assign prdata = prdata_ff;
  assign pready = pready_ff;
  assign pslverr = pslverr_ff;
  assign cfg_if.cfg = cfg_ff;

endmodule : pfs_apb_bank
`default_nettype wire

// >>> pfs_pin_slice.sv
// pfs_pin_slice: output driver of one pin, fed by its decoded function
`timescale 1ns/100ps
`default_nettype none
module pfs_pin_slice #(
  parameter int NF = pfs_pkg::NFN
) (
  input wire logic pclk,
  input wire logic presetn,
  input wire pfs_pkg::pfs_fn_t fn,
  input wire logic analog,
  input wire logic [NF-1:0] fn_out,
  input wire logic [NF-1:0] fn_oe,
  output logic pin_out,
  output logic pin_oe
);
  import pfs_pkg::*;

  logic pin_out_ff;
  logic pin_oe_ff;
  logic nxt_pin_out;
  logic nxt_pin_oe;

  always_comb begin
    nxt_pin_out = 1'b0;
    nxt_pin_oe = 1'b0;
    if (fn != FN_NONE && !analog) begin
      nxt_pin_out = fn_out[fn];
      nxt_pin_oe = fn_oe[fn];
    end
  end

  // registered so the pad never sees decode glitches
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      pin_out_ff <= 1'b0;
      pin_oe_ff <= 1'b0;
    end else begin
      pin_out_ff <= nxt_pin_out;
      pin_oe_ff <= nxt_pin_oe;
    end
  end

  assign pin_out = pin_out_ff;
  assign pin_oe = pin_oe_ff;

endmodule : pfs_pin_slice
`default_nettype wire

// >>> pfs_port_mux.sv
// pfs_port_mux: function select for port 2, 3 and 7 pins, apb registers
`timescale 1ns/100ps
`default_nettype none
// Behaviour
// [R1] 6-bit code per pin; zero leaves pin floating
// [R2] P20 codes 1-5: mtu, clocks, timer4 reset
// [R3] P20: timer2, trigger, spi clocks, hall W
// [R4] P20: serial008 handshake, receive, driver enable
// [R5] P21: timer6, spi0 out, hall U, serial008 transmit
// [R6] P24: spi0 clock, serial008 handshake, clock, enable
// [R7] P27: timers 2/6, oe request 9, spi clocks
// [R8] P30: spi0 ss0, hall V, serial008 signals
// [R9] P31: spi-a ss1, spi0 ss1, hall U
// [R10] P32/P33 gpt7 A/B; P33 period output
// [R11] P70: serial009 handshake and driver enable
// [R12] P71: spi0 master in, gpt0 A
// [R13] P72: gpt5 A inverted, pwm V upper
// [R14] interrupt flag makes pin an irq input
// [R15] port 2 pins to irq lines 7,6,10,11,4,15
// [R16] port 3 pins to irq lines 7,6,12,13
// [R17] analog flag on P20/P21 gives converter inputs
// [R18] port 3 registers only pins 0-3,6,7
// [R19] unlisted codes behave as floating pin
module pfs_port_mux (
  input wire logic pclk,
  input wire logic presetn,
  input wire logic psel,
  input wire logic penable,
  input wire logic pwrite,
  input wire logic [pfs_pkg::ADDR_W-1:0] paddr,
  input wire logic [31:0] pwdata,
  output logic [31:0] prdata,
  output logic pready,
  output logic pslverr,
  input wire logic [pfs_pkg::NFN-1:0] fn_out,
  input wire logic [pfs_pkg::NFN-1:0] fn_oe,
  input wire logic [pfs_pkg::NPIN-1:0] pin_in,
  output logic [pfs_pkg::NPIN-1:0] pin_out,
  output logic [pfs_pkg::NPIN-1:0] pin_oe,
  output logic [pfs_pkg::NFN-1:0] fn_in,
  output logic [pfs_pkg::NIRQ-1:0] irq_req,
  output logic [pfs_pkg::NANA-1:0] analog_en
);
  import pfs_pkg::*;

  // ****************************************
  // routing decode
  // ****************************************
  function automatic pfs_fn_t route_fn(input int pin, input logic [5:0] code);
    route_fn = FN_NONE; // R1 R19
    case (pin)
      PIN_P20: begin
        case (code)
          CODE_MTU_A: route_fn = FN_MTU_CH9_C_IO; // R2
          CODE_MTU_A_INV: route_fn = FN_MTU_CH9_C_IO_INVERTED; // R2
          CODE_MTU_B: route_fn = FN_MTU_EXT_CLOCK_B; // R2
          CODE_MTU_B_INV: route_fn = FN_MTU_EXT_CLOCK_B_INVERTED; // R2
          CODE_TMR_A: route_fn = FN_TIMER4_RESET_INPUT; // R2
          CODE_TMR_B: route_fn = FN_TIMER2_OUTPUT; // R3
          CODE_ADC_TRG: route_fn = FN_CONVERTER0_TRIGGER_INPUT; // R3
          CODE_SPIA: route_fn = FN_SPI_A_CLOCK; // R3
          CODE_SPI0: route_fn = FN_SPI_UNIT0_CLOCK; // R3
          CODE_WAVE: route_fn = FN_HALL_W_INPUT; // R3
          CODE_SCI_A: route_fn = FN_SERIAL008_HANDSHAKE_SELECT; // R4
          CODE_SCI_B: route_fn = FN_SERIAL008_RECEIVE; // R4
          CODE_SCI_C: route_fn = FN_SERIAL008_DRIVER_ENABLE; // R4
          default: route_fn = FN_NONE; // R19
        endcase
      end
      PIN_P21: begin
        case (code)
          CODE_TMR_B: route_fn = FN_TIMER6_OUTPUT; // R5
          CODE_SPI0: route_fn = FN_SPI_UNIT0_MASTER_OUT; // R5
          CODE_WAVE: route_fn = FN_HALL_U_INPUT; // R5
          CODE_SCI_A: route_fn = FN_SERIAL008_TRANSMIT; // R5
          default: route_fn = FN_NONE; // R19
        endcase
      end
      PIN_P24: begin
        case (code)
          CODE_SPI0: route_fn = FN_SPI_UNIT0_CLOCK; // R6
          CODE_SCI_A: route_fn = FN_SERIAL008_HANDSHAKE_SELECT; // R6
          CODE_SCI_B: route_fn = FN_SERIAL008_CLOCK; // R6
          CODE_SCI_C: route_fn = FN_SERIAL008_DRIVER_ENABLE; // R6
          default: route_fn = FN_NONE; // R19
        endcase
      end
      PIN_P27: begin
        case (code)
          CODE_TMR_A: route_fn = FN_TIMER2_OUTPUT; // R7
          CODE_TMR_B: route_fn = FN_TIMER6_OUTPUT; // R7
          CODE_POE: route_fn = FN_OUTPUT_ENABLE_REQUEST9; // R7
          CODE_SPIA: route_fn = FN_SPI_A_CLOCK; // R7
          CODE_SPI0: route_fn = FN_SPI_UNIT0_CLOCK; // R7
          default: route_fn = FN_NONE; // R19
        endcase
      end
      PIN_P30: begin
        case (code)
          CODE_SPI0: route_fn = FN_SPI_UNIT0_SLAVE_SELECT0; // R8
          CODE_WAVE: route_fn = FN_HALL_V_INPUT; // R8
          CODE_SCI_A: route_fn = FN_SERIAL008_CLOCK; // R8
          CODE_SCI_B: route_fn = FN_SERIAL008_HANDSHAKE_SELECT; // R8
          CODE_SCI_C: route_fn = FN_SERIAL008_DRIVER_ENABLE; // R8
          default: route_fn = FN_NONE; // R19
        endcase
      end
      PIN_P31: begin
        case (code)
          CODE_SPIA: route_fn = FN_SPI_A_SLAVE_SELECT1; // R9
          CODE_SPI0: route_fn = FN_SPI_UNIT0_SLAVE_SELECT1; // R9
          CODE_WAVE: route_fn = FN_HALL_U_INPUT; // R9
          default: route_fn = FN_NONE; // R19
        endcase
      end
      PIN_P32: begin
        case (code)
          CODE_GPT_B: route_fn = FN_GPT_CH7_A_IO; // R10
          CODE_GPT_B_INV: route_fn = FN_GPT_CH7_A_IO_INVERTED; // R10
          default: route_fn = FN_NONE; // R19
        endcase
      end
      PIN_P33: begin
        case (code)
          CODE_GPT_B: route_fn = FN_GPT_CH7_B_IO; // R10
          CODE_GPT_B_INV: route_fn = FN_GPT_CH7_B_IO_INVERTED; // R10
          CODE_WAVE: route_fn = FN_COMPLEMENTARY_PERIOD_OUTPUT00; // R10
          default: route_fn = FN_NONE; // R19
        endcase
      end
      PIN_P70: begin
        case (code)
          CODE_SCI_A: route_fn = FN_SERIAL009_HANDSHAKE_SELECT; // R11
          CODE_SCI_C: route_fn = FN_SERIAL009_DRIVER_ENABLE; // R11
          default: route_fn = FN_NONE; // R19
        endcase
      end
      PIN_P71: begin
        case (code)
          CODE_SPI0: route_fn = FN_SPI_UNIT0_MASTER_IN; // R12
          CODE_GPT_A: route_fn = FN_GPT_CH0_A_IO; // R12
          default: route_fn = FN_NONE; // R19
        endcase
      end
      PIN_P72: begin
        case (code)
          CODE_GPT_B_INV: route_fn = FN_GPT_CH5_A_IO_INVERTED; // R13
          CODE_WAVE: route_fn = FN_PWM_V_UPPER_OUTPUT; // R13
          default: route_fn = FN_NONE; // R19
        endcase
      end
      // P22, P23, P36, P37: only the floating choice is offered here
      default: route_fn = FN_NONE; // R18 R19
    endcase
  endfunction : route_fn

  // ****************************************
  // registers
  // ****************************************
  pfs_cfg_if cfg_if ();

  pfs_apb_bank u_bank (
    .pclk(pclk),
    .presetn(presetn),
    .psel(psel),
    .penable(penable),
    .pwrite(pwrite),
    .paddr(paddr),
    .pwdata(pwdata),
    .prdata(prdata),
    .pready(pready),
    .pslverr(pslverr),
    .cfg_if(cfg_if.bank)
  ); // R18

  pfs_fn_t pin_fn [NPIN];
  logic [NPIN-1:0] irq_flag;
  logic [NPIN-1:0] ana_flag;

  // ****************************************
  // per-pin output drivers
  // ****************************************
  for (genvar p = 0; p < NPIN; p++) begin : g_pin
    always_comb begin
      pin_fn[p] = route_fn(p, cfg_if.cfg[p][SEL_LSB +: SEL_W]); // R1
      irq_flag[p] = cfg_if.cfg[p][IRQ_FLAG_BIT]; // R14
      ana_flag[p] = cfg_if.cfg[p][ANA_FLAG_BIT]; // R17
    end

    pfs_pin_slice #(
      .NF(NFN)
    ) u_slice (
      .pclk(pclk),
      .presetn(presetn),
      .fn(pin_fn[p]),
      .analog(ana_flag[p]),
      .fn_out(fn_out),
      .fn_oe(fn_oe),
      .pin_out(pin_out[p]),
      .pin_oe(pin_oe[p])
    ); // R1 R17
  end

  // ****************************************
  // pin to peripheral input path
  // ****************************************
  logic [NFN-1:0] fn_in_ff;
  logic [NFN-1:0] nxt_fn_in;

  // a function routed to two pins sees the or of both
  always_comb begin
    nxt_fn_in = '0;
    for (int p = 0; p < NPIN; p++) begin
      if (pin_fn[p] != FN_NONE && !ana_flag[p]) begin
        nxt_fn_in[pin_fn[p]] = nxt_fn_in[pin_fn[p]] | pin_in[p]; // R17
      end
    end
  end

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      fn_in_ff <= '0;
    end else begin
      fn_in_ff <= nxt_fn_in;
    end
  end

  // ****************************************
  // external interrupt lines
  // ****************************************
  logic [NIRQ-1:0] irq_ff;
  logic [NIRQ-1:0] nxt_irq;

  // P20 and P30 share a line, as do P21 and P31; enable only one of each
  always_comb begin
    nxt_irq = '0;
    for (int p = 0; p < NPIN; p++) begin
      if (irq_flag[p] && irq_of(p) != NO_IRQ) begin
        nxt_irq[irq_of(p)] = nxt_irq[irq_of(p)] | pin_in[p]; // R14 R15 R16
      end
    end
  end

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      irq_ff <= '0;
    end else begin
      irq_ff <= nxt_irq;
    end
  end

  // ****************************************
  // analog enables
  // ****************************************
  logic [NANA-1:0] ana_ff;

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      ana_ff <= '0;
    end else begin
      ana_ff <= {ana_flag[PIN_P21], ana_flag[PIN_P20]}; // R17
    end
  end

  assign fn_in = fn_in_ff;
  assign irq_req = irq_ff;
  assign analog_en = ana_ff;

  // ****************************************
  // checks
  // ****************************************
  default clocking cb @(posedge pclk);
  endclocking
  default disable iff (!presetn);

  logic [5:0] sel20;
  logic [5:0] sel21;
  logic [5:0] sel72;
  assign sel20 = cfg_if.cfg[PIN_P20][SEL_LSB +: SEL_W];
  assign sel21 = cfg_if.cfg[PIN_P21][SEL_LSB +: SEL_W];
  assign sel72 = cfg_if.cfg[PIN_P72][SEL_LSB +: SEL_W];

  sequence s_p20_mtu;
    sel20 == CODE_MTU_A && !ana_flag[PIN_P20];
  endsequence

  AST_HIZ_NO_DRIVE: assert property ( // R1
    sel20 == CODE_HIZ |=> !pin_oe[PIN_P20])
    else $error("floating code still drives pin");

  AST_P20_MTU_ROUTE: assert property ( // R2
    s_p20_mtu ##1 s_p20_mtu |->
      pin_out[PIN_P20] == $past(fn_out[FN_MTU_CH9_C_IO])
      && pin_oe[PIN_P20] == $past(fn_oe[FN_MTU_CH9_C_IO]))
    else $error("mtu channel 9 C not on P20");

  AST_P20_HALL_IN: assert property ( // R3
    sel20 == CODE_WAVE && !ana_flag[PIN_P20] |=>
      fn_in[FN_HALL_W_INPUT] >= $past(pin_in[PIN_P20]))
    else $error("P20 level missing on hall W input");

  AST_P21_TX_ROUTE: assert property ( // R5
    sel21 == CODE_SCI_A && !ana_flag[PIN_P21] |=>
      pin_oe[PIN_P21] == $past(fn_oe[FN_SERIAL008_TRANSMIT]))
    else $error("serial008 transmit not on P21");

  AST_P72_PWM_ROUTE: assert property ( // R13
    sel72 == CODE_WAVE |=>
      pin_out[PIN_P72] == $past(fn_out[FN_PWM_V_UPPER_OUTPUT]))
    else $error("pwm V upper not on P72");

  AST_IRQ7_FOLLOWS_P20: assert property ( // R15
    irq_flag[PIN_P20] && !irq_flag[PIN_P30] |=>
      irq_req[7] == $past(pin_in[PIN_P20]))
    else $error("irq line 7 does not follow P20");

  AST_IRQ13_FOLLOWS_P33: assert property ( // R16
    irq_flag[PIN_P33] |=> irq_req[13] == $past(pin_in[PIN_P33]))
    else $error("irq line 13 does not follow P33");

  AST_IRQ_FLAG_OFF: assert property ( // R14
    !irq_flag[PIN_P24] |=> !irq_req[4])
    else $error("irq line 4 raised with flag clear");

  AST_ANALOG_QUIET: assert property ( // R17
    ana_flag[PIN_P21] |=> !pin_oe[PIN_P21] && analog_en[1])
    else $error("analog P21 still driven");

  AST_UNLISTED_CODE: assert property ( // R19
    sel21 == CODE_MTU_B_INV |=> !pin_oe[PIN_P21])
    else $error("unlisted code drives P21");

  AST_P37_MAPPED: assert property ( // R18
    psel && !penable && paddr == ADDR_W'(PIN_P37 * REG_STRIDE) |=>
      pready && !pslverr)
    else $error("register of P37 refused");

  AST_PAST_END_ERR: assert property ( // R18
    psel && !penable && paddr == ADDR_W'(NPIN * REG_STRIDE) |=>
      pready && pslverr)
    else $error("access beyond last register accepted");

endmodule : pfs_port_mux
`default_nettype wire

// >>> pfs_far_model.sv
// pfs_far_model: peripherals and outside pads facing the pin mux
`timescale 1ns/100ps
`default_nettype none
module pfs_far_model (
  input wire logic pclk,
  input wire logic [pfs_pkg::NFN-1:0] fn_src,
  input wire logic [pfs_pkg::NFN-1:0] oe_src,
  input wire logic [pfs_pkg::NPIN-1:0] ext_src,
  input wire logic [pfs_pkg::NPIN-1:0] pin_out,
  input wire logic [pfs_pkg::NPIN-1:0] pin_oe,
  output logic [pfs_pkg::NFN-1:0] fn_out,
  output logic [pfs_pkg::NFN-1:0] fn_oe,
  output logic [pfs_pkg::NPIN-1:0] pin_in
);
  import pfs_pkg::*;
  // ****************************************
  // peripheral side
  // ****************************************
  logic [NFN-1:0] out_q = '0;
  logic [NFN-1:0] oe_q = '0;
  // levels leave real peripherals from flops, so they move after the edge
  always @(posedge pclk) begin
    out_q <= fn_src;
    oe_q <= oe_src;
  end
  assign fn_out = out_q;
  assign fn_oe = oe_q;
  // ****************************************
  // pad side
  // ****************************************
  // outside device only shows its level while the mux lets go
  assign pin_in = (pin_oe & pin_out) | (~pin_oe & ext_src);
endmodule : pfs_far_model
`default_nettype wire

// >>> tb_port_pin_function_select.sv
// tb_port_pin_function_select: self-checking bench of the pin mux
`timescale 1ns/100ps
`default_nettype none
module tb_port_pin_function_select;
  import pfs_pkg::*;
  typedef struct {bit mux; int pin; int fn; logic [39:0] exp;} pfs_note_t;
  logic pclk, presetn, psel, penable, pwrite, pready, pslverr, look;
  logic [ADDR_W-1:0] paddr;
  logic [31:0] pwdata, prdata;
  logic [NFN-1:0] fn_out, fn_oe, fn_in, fn_src, oe_src;
  logic [NPIN-1:0] pin_in, pin_out, pin_oe, ext_src;
  logic [NIRQ-1:0] irq_req;
  logic [NANA-1:0] analog_en;
  logic [15:0] lfsr;
  int n_errors, n_compared;
  pfs_note_t notes[$];
  // {pin, code, function}
  localparam logic [15:0] RT[45] = '{16'h0041, 16'h00C2, 16'h0083,
    16'h0104, 16'h0145, 16'h0186, 16'h0248, 16'h0349, 16'h038A, 16'h0610,
    16'h0B13, 16'h0B54, 16'h0B97, 16'h1187, 16'h138B, 16'h1611, 16'h1B15,
    16'h438A, 16'h4B13, 16'h4B56, 16'h4B97, 16'h5146, 16'h5187, 16'h51DA,
    16'h5349, 16'h538A, 16'h638D, 16'h6612, 16'h6B16, 16'h6B53, 16'h6B97,
    16'h734F, 16'h738E, 16'h7611, 16'h855B, 16'h85DC, 16'h955D, 16'h95DE,
    16'h9621, 16'hCB18, 16'hCB99, 16'hD38C, 16'hD51F, 16'hE5E0, 16'hE622};
  localparam int IRQL[NPIN] = '{7, 6, 10, 11, 4, 15, 7, 6, 12, 13,
    -1, -1, -1, -1, -1};

  pfs_port_mux u_dut (.pclk, .presetn, .psel, .penable, .pwrite, .paddr,
    .pwdata, .prdata, .pready, .pslverr, .fn_out, .fn_oe, .pin_in,
    .pin_out, .pin_oe, .fn_in, .irq_req, .analog_en);
  pfs_far_model u_far (.pclk, .fn_src, .oe_src, .ext_src, .pin_out,
    .pin_oe, .fn_out, .fn_oe, .pin_in);

  initial begin
    pclk = 1'h0;
    forever #5 pclk = ~pclk;
  end

  // ****************************************
  // result watcher
  // ****************************************
  always @(posedge pclk) begin : mon
    pfs_note_t nt;
    logic [39:0] obs;
    if (look === 1'h1 || (psel === 1'h1 && penable === 1'h1 &&
        pready === 1'h1 && pwrite === 1'h0)) begin
      nt = notes.pop_front();
      if (nt.mux)
        obs = {19'h0, irq_req, analog_en, pin_oe[nt.pin],
          pin_out[nt.pin] & pin_oe[nt.pin],
          (nt.fn == 0) ? |fn_in : fn_in[nt.fn]};
      else
        obs = {7'h0, pslverr, prdata};
      n_compared++;
      if (obs !== nt.exp) begin
        n_errors++;
        $display("mismatch %s pin %0d: expected %h seen %h",
          nt.mux ? "mux" : "apb", nt.pin, nt.exp, obs);
      end
    end
  end

  // ****************************************
  // drivers
  // ****************************************
  function automatic logic [15:0] nx(input logic [15:0] x);
    return {x[14:0], x[15] ^ x[13] ^ x[12] ^ x[10]};
  endfunction : nx

  task automatic apb(input logic w, input int a, input logic [31:0] d);
    int n;
    psel <= 1'h1;
    penable <= 1'h0;
    pwrite <= w;
    paddr <= ADDR_W'(a);
    pwdata <= d;
    @(posedge pclk);
    penable <= 1'h1;
    n = 0;
    do begin
      @(posedge pclk);
      n++;
    end while (pready !== 1'h1);
    // slave answers in the first access cycle; the watchdog ends a hang
    if (n != 1) begin
      n_errors++;
      $display("mismatch pready wait: expected %0d seen %0d", 1, n);
    end
    psel <= 1'h0;
    penable <= 1'h0;
    // one idle edge keeps back-to-back calls from double driving psel
    @(posedge pclk);
  endtask : apb

  task automatic rd(input int a, input logic [32:0] e);
    notes.push_back('{1'h0, a / REG_STRIDE, 0, {7'h0, e}});
    apb(1'h0, a, 32'h0);
  endtask : rd

  // outputs trail the far side by partner flop, mux flop and pad return
  task automatic peek(input int p, input int f, input logic [20:0] e);
    repeat (4) @(posedge pclk);
    notes.push_back('{1'h1, p, f, {19'h0, e}});
    look <= 1'h1;
    @(posedge pclk);
    look <= 1'h0;
  endtask : peek

  task automatic route(input int p, input logic [7:0] cfg, input int f,
                       input logic live, input logic [1:0] ana);
    logic [NFN-1:0] r;
    logic [NPIN-1:0] x;
    lfsr = nx(lfsr);
    r = NFN'({lfsr, ~lfsr, lfsr});
    x = NPIN'(~lfsr);
    apb(1'h1, p * REG_STRIDE, {24'h0, cfg});
    fn_src <= r;
    oe_src <= '1;
    ext_src <= x;
    peek(p, f, {16'h0, ana, live, live & r[f], live & r[f]});
    oe_src <= '0;
    peek(p, f, {16'h0, ana, 2'h0, live & x[p]});
    apb(1'h1, p * REG_STRIDE, 32'h0);
  endtask : route

  task automatic give_verdict();
    if (n_errors == 0 && n_compared > 0)
      $display("[ PASS ]");
    else
      $display("[ FAIL ]");
    $finish;
  endtask : give_verdict

  // ****************************************
  // scenarios
  // ****************************************
  initial begin
    presetn = 1'h0;
    psel = 1'h0;
    penable = 1'h0;
    pwrite = 1'h0;
    paddr = '0;
    pwdata = 32'h0;
    look = 1'h0;
    fn_src = '0;
    oe_src = '0;
    ext_src = '0;
    lfsr = 16'h6A02;
    repeat (8) @(posedge pclk);
    presetn <= 1'h1;
    @(posedge pclk);
    for (int p = 0; p < NPIN; p++) begin
      lfsr = nx(lfsr);
      rd(p * REG_STRIDE, {25'h0, CFG_RESET});
      apb(1'h1, p * REG_STRIDE, {lfsr, lfsr});
      rd(p * REG_STRIDE, {25'h0, (p <= PIN_P21) & lfsr[7], lfsr[6:0]});
      apb(1'h1, p * REG_STRIDE, 32'h0);
    end
    rd(32'h3C, {1'h1, 32'h0});
    rd(32'h01, {1'h1, 32'h0});
    foreach (RT[i])
      route(RT[i][15:12], {2'h0, RT[i][11:6]}, RT[i][5:0], 1'h1, 2'h0);
    route(PIN_P20, 8'h00, 0, 1'h0, 2'h0);
    route(PIN_P20, 8'h3F, 0, 1'h0, 2'h0);
    route(PIN_P70, 8'h2D, 0, 1'h0, 2'h0);
    route(PIN_P21, 8'h04, 0, 1'h0, 2'h0);
    route(PIN_P22, 8'h01, 0, 1'h0, 2'h0);
    route(PIN_P20, 8'h81, 1, 1'h0, 2'h1);
    route(PIN_P21, 8'h86, 7, 1'h0, 2'h2);
    for (int p = 0; p < NPIN; p++) begin
      apb(1'h1, p * REG_STRIDE, 32'h40);
      ext_src <= NPIN'(1) << p;
      oe_src <= '0;
      peek(p, 0, {(IRQL[p] < 0) ? 16'h0 : 16'h1 << IRQL[p], 5'h0});
      ext_src <= '0;
      peek(p, 0, 21'h0);
      apb(1'h1, p * REG_STRIDE, 32'h0);
    end
    if (notes.size() != 0) begin
      n_errors++;
      $display("mismatch notes left: expected %0d seen %0d", 0,
        notes.size());
    end
    give_verdict();
  end

  // run needs about 1270 cycles; this leaves ample margin
  initial begin
    repeat (20000) @(posedge pclk);
    n_errors++;
    give_verdict();
  end
endmodule : tb_port_pin_function_select
`default_nettype wire
